/* File: core/wspc_pkg.sv */
// Package for the waveform sequence playback controller.
// Assumes one 100 MHz clock and a plain single-cycle register port.
package wspc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int LOOP_W = 20;
    localparam int SEL_W = 8;
    localparam int PIN_W = 12;
    // Register offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_SEQ_LOOPS = 8'h08;
    localparam logic [7:0] OFS_TBL_IDX = 8'h0c;
    localparam logic [7:0] OFS_TBL_DATA = 8'h10;
    localparam logic [7:0] OFS_TBL_LEN = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_DYN_SEL = 8'h1c;
    // Control register fields.
    localparam int CTRL_RUN_LSB = 0;
    localparam int CTRL_ADV_LSB = 2;
    localparam int CTRL_ARMED = 4;
    localparam int CTRL_IDLE_WAVE = 5;
    localparam int CTRL_EN_EVENT = 6;
    localparam int CTRL_INIT_LSB = 7;
    localparam int CTRL_ADVANCED = 9;
    localparam int CTRL_DYN_EN = 10;
    localparam int CTRL_W = 11;
    localparam logic [10:0] CTRL_RESET = 11'h000;
    // Command register pulses.
    localparam int CMD_ENABLE = 0;
    localparam int CMD_ABORT = 1;
    localparam int CMD_INIT = 2;
    // Table data word fields.
    localparam int TBL_JUMP = 8;
    localparam int TBL_LOOP_LSB = 9;
    localparam logic [19:0] LOOPS_RESET = 20'h00001;
    // Pin vector positions after synchronising.
    localparam int PIN_TRIG = 0;
    localparam int PIN_EVENT = 1;
    localparam int PIN_BUTTON = 2;
    localparam int PIN_SEL_LSB = 3;
    typedef enum logic [1:0] {RUN_CONT = 2'b00, RUN_TRIG = 2'b01, RUN_GATE = 2'b10} wspc_run_e;
    typedef enum logic [1:0] {ADV_AUTO = 2'b00, ADV_ONCE = 2'b01, ADV_STEP = 2'b10} wspc_adv_e;
    typedef enum logic [1:0] {INIT_PANEL = 2'b00, INIT_BUS = 2'b01, INIT_TRIG = 2'b10} wspc_init_e;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_PLAY = 2'b10
    } wspc_state_e;
endpackage : wspc_pkg

/* File: core/wspc_top.sv */
// Playback controller that walks a step table and tells the waveform engine what to play.
// Assumes the engine pulses wave_end on the same clock at the end of each waveform pass;
// trigger, event, button and select pins are asynchronous and are synchronised here.
// What this block does
// - Continuous run mode plays the waveform repeatedly; it stops only under once advance or on abort.
// - Triggered run mode idles until a trigger, then plays once.
// - Gated run mode idles until gate true, plays while gate stays true.
// - Auto advance replays the whole sequence endlessly in continuous and gated run modes.
// - Once advance plays the sequence once, then returns to idle; gated run mode ignores it and keeps playing.
// - Stepped advance moves to the next step only on an event.
// - Self-armed starts generating without any control signal.
// - Armed withholds generation until a control signal enables it.
// - Before start, output shows first-sample hold or first waveform, as selected.
// - Enable source acts only when armed, ignored otherwise.
// - With event as enable source, an event transition enables output.
// - Bus abort halts all output; ignored when self-armed.
// - Initiate source starts playback only in triggered and gated modes.
// - Choosing bus initiate disables the front-panel button.
// - Each waveform repeats its programmed wave loop count after initiate.
// - The sequence repeats its programmed sequence loop count after initiate.
// - Jump flag clear: advance as soon as the step's loops complete.
// - Jump flag set: replay the step until an event, then advance.
// - Starts in normal sequencing; advanced mode steps select whole sequences.
// - Eight select lines give binary index 0 to 255, line 1 least significant.
// - The sequence switches only when the validating strobe is asserted.
// - Stepped advance treats every step as having its jump flag set.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ns
module wspc_top #(
    parameter int STEPS = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [wspc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [wspc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [wspc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic trigger_pin,
    input wire logic event_pin,
    input wire logic button_pin,
    input wire logic [wspc_pkg::SEL_W-1:0] dyn_sel_pin,
    input wire logic dyn_strobe_pin,
    input wire logic wave_end,
    output logic play_active,
    output logic first_sample_hold_idle,
    output logic [wspc_pkg::SEL_W-1:0] play_index,
    output logic [$clog2(STEPS)-1:0] play_step,
    output logic play_advanced
);
    import wspc_pkg::*;
    localparam int IW = $clog2(STEPS);

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Register state.
    logic [CTRL_W-1:0] ctrl_ff;
    logic [LOOP_W-1:0] seq_loops_ff;
    logic [IW-1:0] tbl_idx_ff;
    logic [IW:0] tbl_len_ff;
    logic [SEL_W-1:0] tbl_seg_ff [STEPS];
    logic tbl_jump_ff [STEPS];
    logic [LOOP_W-1:0] tbl_loops_ff [STEPS];
    logic [DATA_W-1:0] rdata_ff;
    // Sequencer state.
    wspc_state_e state_ff, nxt_state;
    logic [IW-1:0] step_ff, nxt_step;
    logic [LOOP_W-1:0] wcnt_ff, nxt_wcnt;
    logic [LOOP_W-1:0] scnt_ff, nxt_scnt;
    logic enabled_ff, jump_pend_ff, nxt_consume;
    // Pin synchronisers and filtered levels.
    logic [PIN_W-1:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_f_ff, pin_prev_ff;
    logic [SEL_W-1:0] dyn_sel_ff;
    logic [SEL_W-1:0] out_index_ff;
    logic out_play_ff, out_hold_ff, out_adv_ff;
    logic [IW-1:0] out_step_ff;

    function automatic logic is_wr(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        return reg_wr && (a == ofs);
    endfunction : is_wr

    function automatic logic [LOOP_W-1:0] at_least_one(input logic [LOOP_W-1:0] v);
        return (v == '0) ? LOOPS_RESET : v;
    endfunction : at_least_one

    wire wspc_run_e run_mode = wspc_run_e'(ctrl_ff[CTRL_RUN_LSB +: 2]);
    wire wspc_adv_e adv_mode = wspc_adv_e'(ctrl_ff[CTRL_ADV_LSB +: 2]);
    wire wspc_init_e init_src = wspc_init_e'(ctrl_ff[CTRL_INIT_LSB +: 2]);
    wire armed = ctrl_ff[CTRL_ARMED];
    wire dyn_en = ctrl_ff[CTRL_DYN_EN];
    wire cmd_enable = is_wr(reg_addr, OFS_CMD) && reg_wdata[CMD_ENABLE];
    wire cmd_abort = is_wr(reg_addr, OFS_CMD) && reg_wdata[CMD_ABORT];
    wire cmd_init = is_wr(reg_addr, OFS_CMD) && reg_wdata[CMD_INIT];
    wire [PIN_W-1:0] pin_rise = pin_f_ff & ~pin_prev_ff;
    wire trig_rise = pin_rise[PIN_TRIG];
    wire event_rise = pin_rise[PIN_EVENT];
    wire button_rise = pin_rise[PIN_BUTTON];
    wire strobe_rise = pin_rise[PIN_W-1];
    wire [SEL_W-1:0] sel_now = pin_f_ff[PIN_SEL_LSB +: SEL_W];

    // A change is taken only once the second and third stages agree.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
            pin_s3_ff <= '0;
            pin_f_ff <= '0;
            pin_prev_ff <= '0;
        end else begin
            pin_s1_ff <= {dyn_strobe_pin, dyn_sel_pin, button_pin, event_pin, trigger_pin};
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            for (int i = 0; i < PIN_W; i++) begin
                if (pin_s2_ff[i] == pin_s3_ff[i]) begin
                    pin_f_ff[i] <= pin_s3_ff[i];
                end
            end
            pin_prev_ff <= pin_f_ff;
        end
    end

    // Line 1 is bit 0, so all-low is index 0 and all-high is index 255.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dyn_sel_ff <= '0;
        end else if (strobe_rise) begin
            dyn_sel_ff <= sel_now;
        end
    end

    a_dyn_take: assert property (strobe_rise |=> dyn_sel_ff == $past(sel_now))
        else $error("select code not taken on strobe");
    a_dyn_hold: assert property (!strobe_rise |=> $stable(dyn_sel_ff))
        else $error("sequence changed without strobe");

    // Gate level follows the button when it is the source, otherwise the trigger pin.
    wire gate = (init_src == INIT_PANEL) ? pin_f_ff[PIN_BUTTON] : pin_f_ff[PIN_TRIG];
    // Bus initiate shuts out the button, since only the selected source is heard.
    wire init_pulse = (init_src == INIT_BUS) ? cmd_init :
                      (init_src == INIT_TRIG) ? trig_rise : button_rise;
    wire abort_act = cmd_abort && armed;
    wire en_pulse = ctrl_ff[CTRL_EN_EVENT] ? event_rise : cmd_enable;

    // Self-armed is always enabled; armed waits for the enable source.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            enabled_ff <= 1'b0;
        end else if (!armed) begin
            enabled_ff <= 1'b1;
        end else if (en_pulse) begin
            enabled_ff <= 1'b1;
        end else if (abort_act || (state_ff == ST_PLAY && nxt_state == ST_IDLE)) begin
            enabled_ff <= 1'b0;
        end
    end

    // The releasing edge of reset still resets the flops,
    // so attempts that start on it are skipped.
    a_self_armed: assert property (!rst && !armed |=> enabled_ff)
        else $error("self-armed block not enabled");
    a_arm_withhold: assert property (armed && !enabled_ff && state_ff == ST_IDLE
        |=> !out_play_ff)
        else $error("armed block played without enable");

    wire [LOOP_W-1:0] step_loops = at_least_one(tbl_loops_ff[step_ff]);
    wire wave_done = (wcnt_ff + 1'b1) >= step_loops;
    wire jump_eff = (adv_mode == ADV_STEP) || tbl_jump_ff[step_ff];
    wire last_step = ({1'b0, step_ff} + 1'b1) >= tbl_len_ff;
    wire seq_done = (scnt_ff + 1'b1) >= at_least_one(seq_loops_ff);

    always_comb begin
        nxt_state = state_ff;
        nxt_step = step_ff;
        nxt_wcnt = wcnt_ff;
        nxt_scnt = scnt_ff;
        nxt_consume = 1'b0;
        unique case (state_ff)
            ST_IDLE: begin
                if (enabled_ff && !abort_act) begin
                    nxt_state = (run_mode == RUN_CONT) ? ST_PLAY : ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!enabled_ff || abort_act) begin
                    nxt_state = ST_IDLE;
                end else if ((run_mode == RUN_TRIG && init_pulse) ||
                             (run_mode == RUN_GATE && gate)) begin
                    nxt_state = ST_PLAY;
                end
            end
            ST_PLAY: begin
                if (abort_act) begin
                    nxt_state = ST_IDLE;
                end else if (wave_end) begin
                    if (run_mode == RUN_GATE && !gate) begin
                        nxt_state = ST_WAIT;
                    end else if (!wave_done) begin
                        nxt_wcnt = wcnt_ff + 1'b1;
                    end else if (jump_eff && !jump_pend_ff) begin
                        nxt_wcnt = wcnt_ff;
                    end else begin
                        nxt_consume = jump_eff;
                        nxt_wcnt = '0;
                        if (!last_step) begin
                            nxt_step = step_ff + 1'b1;
                        end else begin
                            nxt_step = '0;
                            if (run_mode == RUN_GATE ||
                                (run_mode == RUN_CONT && adv_mode != ADV_ONCE)) begin
                                nxt_scnt = '0;
                            end else if (!seq_done) begin
                                nxt_scnt = scnt_ff + 1'b1;
                            end else begin
                                nxt_scnt = '0;
                                nxt_state = (run_mode == RUN_CONT) ? ST_IDLE : ST_WAIT;
                            end
                        end
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        if (state_ff != ST_PLAY) begin
            nxt_step = '0;
            nxt_wcnt = '0;
            nxt_scnt = '0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            step_ff <= '0;
            wcnt_ff <= '0;
            scnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            step_ff <= nxt_step;
            wcnt_ff <= nxt_wcnt;
            scnt_ff <= nxt_scnt;
        end
    end

    // An event in the cycle that consumes the pending one is kept.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            jump_pend_ff <= 1'b0;
        end else if (state_ff != ST_PLAY) begin
            jump_pend_ff <= 1'b0;
        end else begin
            jump_pend_ff <= event_rise || (jump_pend_ff && !nxt_consume);
        end
    end

    wire play_end = state_ff == ST_PLAY && !abort_act && wave_end &&
                    !(run_mode == RUN_GATE && !gate);
    a_cont_runs: assert property (state_ff == ST_PLAY && run_mode == RUN_CONT &&
        adv_mode == ADV_AUTO && !abort_act |=> state_ff == ST_PLAY)
        else $error("continuous auto playback stopped");
    a_trig_waits: assert property (state_ff == ST_WAIT && run_mode == RUN_TRIG &&
        !init_pulse |=> state_ff != ST_PLAY)
        else $error("triggered mode started without initiate");
    a_gate_drop: assert property (state_ff == ST_PLAY && run_mode == RUN_GATE &&
        !gate && wave_end && !abort_act |=> state_ff == ST_WAIT && !out_play_ff)
        else $error("gated playback outlived the gate");
    a_once_ends: assert property (play_end && run_mode == RUN_CONT &&
        adv_mode == ADV_ONCE && wave_done && !(jump_eff && !jump_pend_ff) && last_step &&
        seq_done |=> state_ff == ST_IDLE)
        else $error("once advance did not return to idle");
    a_jump_dwell: assert property (play_end && wave_done && jump_eff && !jump_pend_ff
        |=> $stable(step_ff) && wcnt_ff == $past(wcnt_ff))
        else $error("step left without an event");
    a_step_adv: assert property (play_end && wave_done && !jump_eff && !last_step
        |=> step_ff == $past(step_ff) + 1'b1 && wcnt_ff == '0)
        else $error("cleared jump flag did not advance");
    a_abort_halt: assert property (state_ff == ST_PLAY && abort_act
        |=> state_ff == ST_IDLE && !out_play_ff)
        else $error("abort did not halt output");
    c_trig_play: cover property (state_ff == ST_WAIT && run_mode == RUN_TRIG ##1
        state_ff == ST_PLAY);
    c_jump_wait: cover property (play_end && jump_eff && !jump_pend_ff ##[1:20] nxt_consume);
    c_dyn_switch: cover property (strobe_rise && dyn_en && sel_now == 8'hff);

    // Outputs come from flops loaded with the next-state values.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            out_play_ff <= 1'b0;
            out_hold_ff <= 1'b1;
            out_index_ff <= '0;
            out_step_ff <= '0;
            out_adv_ff <= 1'b0;
        end else begin
            out_play_ff <= nxt_state == ST_PLAY;
            out_hold_ff <= nxt_state != ST_PLAY && !ctrl_ff[CTRL_IDLE_WAVE];
            out_index_ff <= dyn_en ? dyn_sel_ff : tbl_seg_ff[nxt_step];
            out_step_ff <= nxt_step;
            out_adv_ff <= ctrl_ff[CTRL_ADVANCED];
        end
    end

    a_idle_shows: assert property (!rst && state_ff != ST_PLAY &&
        nxt_state != ST_PLAY && !dyn_en |=> play_index == $past(tbl_seg_ff[0]) &&
        first_sample_hold_idle == !$past(ctrl_ff[CTRL_IDLE_WAVE]))
        else $error("idle output not the selected idle form");

    assign play_active = out_play_ff;
    assign first_sample_hold_idle = out_hold_ff;
    assign play_index = out_index_ff;
    assign play_step = out_step_ff;
    assign play_advanced = out_adv_ff;

    // Register file; advanced mode is off after reset.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_ff <= CTRL_RESET;
            seq_loops_ff <= LOOPS_RESET;
            tbl_idx_ff <= '0;
            tbl_len_ff <= (IW+1)'(1);
        end else begin
            if (is_wr(reg_addr, OFS_CTRL)) begin
                ctrl_ff <= reg_wdata[CTRL_W-1:0];
            end
            if (is_wr(reg_addr, OFS_SEQ_LOOPS)) begin
                seq_loops_ff <= reg_wdata[LOOP_W-1:0];
            end
            if (is_wr(reg_addr, OFS_TBL_IDX)) begin
                tbl_idx_ff <= reg_wdata[IW-1:0];
            end else if (is_wr(reg_addr, OFS_TBL_DATA)) begin
                tbl_idx_ff <= tbl_idx_ff + 1'b1;
            end
            if (is_wr(reg_addr, OFS_TBL_LEN)) begin
                tbl_len_ff <= (reg_wdata[IW:0] == '0) ? (IW+1)'(1) : reg_wdata[IW:0];
            end
        end
    end

    // Table storage has no reset: software loads it before enabling playback.
    always_ff @(posedge clock) begin
        if (is_wr(reg_addr, OFS_TBL_DATA)) begin
            tbl_seg_ff[tbl_idx_ff] <= reg_wdata[SEL_W-1:0];
            tbl_jump_ff[tbl_idx_ff] <= reg_wdata[TBL_JUMP];
            tbl_loops_ff[tbl_idx_ff] <= reg_wdata[TBL_LOOP_LSB +: LOOP_W];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_ff <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                OFS_CTRL: rdata_ff <= DATA_W'(ctrl_ff);
                OFS_SEQ_LOOPS: rdata_ff <= DATA_W'(seq_loops_ff);
                OFS_TBL_IDX: rdata_ff <= DATA_W'(tbl_idx_ff);
                OFS_TBL_DATA: rdata_ff <= DATA_W'({tbl_loops_ff[tbl_idx_ff],
                    tbl_jump_ff[tbl_idx_ff], tbl_seg_ff[tbl_idx_ff]});
                OFS_TBL_LEN: rdata_ff <= DATA_W'(tbl_len_ff);
                OFS_STATUS: rdata_ff <= DATA_W'({scnt_ff, step_ff, jump_pend_ff,
                    enabled_ff, state_ff});
                OFS_DYN_SEL: rdata_ff <= DATA_W'(dyn_sel_ff);
                default: rdata_ff <= '0;
            endcase
        end else begin
            rdata_ff <= '0;
        end
    end

    assign reg_rdata = rdata_ff;
endmodule : wspc_top

/* File: verification/wspc_far_model.sv */
// Far-side model: the external controller on the trigger, event, button and select pins,
// plus a waveform engine that ends one pass every six cycles while playback runs.
// Assumes the bench calls the tasks one at a time from a single thread.
`timescale 1ns/1ns
module wspc_far_model (
    input wire logic clock,
    input wire logic play_active,
    output logic trigger_pin,
    output logic event_pin,
    output logic button_pin,
    output logic [7:0] dyn_sel_pin,
    output logic dyn_strobe_pin,
    output logic wave_end
);
    logic [3:0] lines_ff = 4'h0;
    logic [7:0] code_ff = 8'h00;
    logic [2:0] pass_cnt_ff = 3'h0;
    assign trigger_pin = lines_ff[0];
    assign event_pin = lines_ff[1];
    assign button_pin = lines_ff[2];
    assign dyn_strobe_pin = lines_ff[3];
    assign dyn_sel_pin = code_ff;
    // Only one channel is modelled, so equal sequence lengths never come into play.
    assign wave_end = play_active && (pass_cnt_ff == 3'h5);
    always_ff @(posedge clock) begin
        pass_cnt_ff <= (!play_active || pass_cnt_ff == 3'h5) ? 3'h0 : pass_cnt_ff + 3'h1;
    end
    task automatic set_line(input int pin, input logic val);
        @(posedge clock);
        lines_ff[pin] <= val;
    endtask : set_line
    task automatic pulse(input int pin, input int len);
        set_line(pin, 1'b1);
        repeat (len) @(posedge clock);
        lines_ff[pin] <= 1'b0;
    endtask : pulse
    task automatic set_code(input logic [7:0] code);
        @(posedge clock);
        code_ff <= code;
    endtask : set_code
    // The code settles well before the strobe so the synchronisers see it stable.
    task automatic select(input logic [7:0] code);
        set_code(code);
        repeat (6) @(posedge clock);
        pulse(3, 6);
    endtask : select
endmodule : wspc_far_model

/* File: verification/wspc_top_test.sv */
// Self-checking bench for the playback controller.
// Assumes the far-side model drives every pin and the engine's pass pulse.
`timescale 1ns/1ns
module wspc_top_test;
    import wspc_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = 8'h00;
    logic [DATA_W-1:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic trigger_pin, event_pin, button_pin, dyn_strobe_pin, wave_end;
    logic play_active, first_sample_hold_idle, play_advanced;
    logic [SEL_W-1:0] dyn_sel_pin, play_index;
    logic [3:0] play_step;
    int mismatches = 0;
    int num_checks = 0;
    always #5 clock = ~clock;
    wspc_top i_wspc_top (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trigger_pin(trigger_pin),
        .event_pin(event_pin), .button_pin(button_pin), .dyn_sel_pin(dyn_sel_pin),
        .dyn_strobe_pin(dyn_strobe_pin), .wave_end(wave_end), .play_active(play_active),
        .first_sample_hold_idle(first_sample_hold_idle), .play_index(play_index),
        .play_step(play_step), .play_advanced(play_advanced));
    wspc_far_model i_wspc_far_model (.clock(clock), .play_active(play_active),
        .trigger_pin(trigger_pin), .event_pin(event_pin), .button_pin(button_pin),
        .dyn_sel_pin(dyn_sel_pin), .dyn_strobe_pin(dyn_strobe_pin), .wave_end(wave_end));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp, msg);
    endtask : rd
    task automatic wait_play(input logic lvl, input int lim, input string msg);
        for (int i = 0; i < lim && play_active !== lvl; i++) cyc(1);
        chk(32'(play_active), 32'(lvl), msg);
    endtask : wait_play
    task automatic wait_step(input logic [3:0] val, input int lim, input string msg);
        for (int i = 0; i < lim && play_step !== val; i++) cyc(1);
        chk(32'(play_step), 32'(val), msg);
    endtask : wait_step
    // Table memory survives reset, but its length does not, so it is reloaded every time.
    task automatic setup(input logic [31:0] ctrl, input logic jump0);
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        wr(OFS_CTRL, ctrl);
        if (ctrl[CTRL_ARMED]) wr(OFS_CMD, 32'h2);
        wr(OFS_TBL_IDX, 32'h0);
        wr(OFS_TBL_DATA, {23'h1, jump0, 8'h11});
        wr(OFS_TBL_DATA, {23'h2, 1'b0, 8'h22});
        wr(OFS_TBL_DATA, {23'h1, 1'b0, 8'h33});
        wr(OFS_TBL_LEN, 32'h3);
        wr(OFS_SEQ_LOOPS, 32'h1);
    endtask : setup
    task automatic test_reset();
        wr(OFS_TBL_DATA, 32'h0);
        chk({play_active, first_sample_hold_idle, play_index, play_step}, 32'h1000, "reset outs");
        chk(32'(play_advanced), 32'h0, "normal sequencing at reset");
        rst <= 1'b0;
        wait_play(1'b1, 10, "self-armed start");
        rd(OFS_CTRL, 32'h0, "ctrl reset");
        rd(OFS_SEQ_LOOPS, 32'h1, "seq loops reset");
        rd(OFS_TBL_LEN, 32'h1, "table length reset");
        rd(OFS_CMD, 32'h0, "command reads zero");
        rd(8'h40, 32'h0, "unmapped read");
        $display("test_reset done");
    endtask : test_reset
    task automatic test_auto();
        int n;
        n = 0;
        setup(32'h0, 1'b0);
        wait_step(4'h1, 100, "reach step 1");
        for (int i = 0; i < 100 && play_step === 4'h1; i++) begin
            if (wave_end === 1'b1) n++;
            cyc(1);
        end
        chk(n, 32'h2, "wave loops of step 1");
        wait_step(4'h0, 100, "wrap to step 0");
        wait_step(4'h1, 100, "second pass step 1");
        cyc(2);
        chk(32'(play_index), 32'h22, "index of step 1");
        $display("test_auto done");
    endtask : test_auto
    task automatic test_jump();
        setup(32'h0, 1'b1);
        cyc(40);
        chk(32'(play_step), 32'h0, "dwell on flagged step");
        i_wspc_far_model.pulse(1, 6);
        wait_step(4'h1, 40, "event releases step");
        $display("test_jump done");
    endtask : test_jump
    task automatic test_stepped();
        setup(32'h18, 1'b0);
        wr(OFS_CMD, 32'h1);
        wait_play(1'b1, 10, "stepped enabled");
        cyc(40);
        chk(32'(play_step), 32'h0, "stepped waits");
        i_wspc_far_model.pulse(1, 6);
        wait_step(4'h1, 40, "stepped advance");
        $display("test_stepped done");
    endtask : test_stepped
    task automatic test_once();
        setup(32'h14, 1'b0);
        cyc(20);
        chk(32'(play_active), 32'h0, "armed withholds");
        chk(32'(first_sample_hold_idle), 32'h1, "hold first sample idle");
        wr(OFS_CMD, 32'h1);
        wait_play(1'b1, 10, "bus enable");
        wait_play(1'b0, 200, "once returns to idle");
        $display("test_once done");
    endtask : test_once
    task automatic test_abort();
        setup(32'h10, 1'b0);
        wr(OFS_CMD, 32'h1);
        wait_play(1'b1, 10, "armed run");
        wr(OFS_CMD, 32'h2);
        wait_play(1'b0, 2, "abort halts");
        setup(32'h0, 1'b0);
        wr(OFS_CMD, 32'h2);
        cyc(10);
        chk(32'(play_active), 32'h1, "abort ignored self-armed");
        $display("test_abort done");
    endtask : test_abort
    task automatic test_trig();
        setup(32'h111, 1'b0);
        wr(OFS_CMD, 32'h1);
        cyc(20);
        chk(32'(play_active), 32'h0, "waits for trigger");
        i_wspc_far_model.pulse(0, 6);
        wait_play(1'b1, 12, "trigger starts");
        wait_play(1'b0, 200, "plays once");
        setup(32'h91, 1'b0);
        wr(OFS_CMD, 32'h1);
        i_wspc_far_model.pulse(2, 6);
        cyc(20);
        chk(32'(play_active), 32'h0, "button disabled");
        wr(OFS_CMD, 32'h4);
        wait_play(1'b1, 10, "bus initiate");
        $display("test_trig done");
    endtask : test_trig
    task automatic test_gate();
        setup(32'h112, 1'b0);
        wr(OFS_CMD, 32'h1);
        cyc(20);
        chk(32'(play_active), 32'h0, "waits for gate");
        i_wspc_far_model.set_line(0, 1'b1);
        wait_play(1'b1, 12, "gate opens");
        cyc(60);
        chk(32'(play_active), 32'h1, "plays while gated");
        i_wspc_far_model.set_line(0, 1'b0);
        wait_play(1'b0, 20, "gate closes");
        $display("test_gate done");
    endtask : test_gate
    task automatic test_event_en();
        setup(32'h70, 1'b0);
        cyc(20);
        chk(32'(play_active), 32'h0, "waits for event");
        chk(32'(first_sample_hold_idle), 32'h0, "first waveform idle");
        i_wspc_far_model.pulse(1, 6);
        wait_play(1'b1, 12, "event enables");
        $display("test_event_en done");
    endtask : test_event_en
    task automatic test_dyn();
        logic [7:0] codes [3];
        codes = '{8'h25, 8'hff, 8'h00};
        setup(32'h600, 1'b0);
        cyc(4);
        chk(32'(play_advanced), 32'h1, "advanced mode");
        foreach (codes[i]) begin
            i_wspc_far_model.select(codes[i]);
            cyc(4);
            chk(32'(play_index), 32'(codes[i]), "strobed select");
        end
        i_wspc_far_model.set_code(8'h55);
        cyc(12);
        chk(32'(play_index), 32'h0, "no strobe no change");
        $display("test_dyn done");
    endtask : test_dyn
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #200000;
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test();
    end
    initial begin
        test_reset();
        test_auto();
        test_jump();
        test_stepped();
        test_once();
        test_abort();
        test_trig();
        test_gate();
        test_event_en();
        test_dyn();
        end_of_test();
    end
endmodule : wspc_top_test
